// File: testbench/osc_ctrl_props.sv
`timescale 1ns/1ps
module osc_ctrl_props #(
  parameter bit RING_STOP_ALLOWED = 1'b1
)(
  input wire logic       SYS_CLK,      // Clock.
  input wire logic       NRST,         // Reset.
  input wire logic [3:0] ADDR,         // Address.
  input wire logic       RD,           // Read strobe.
  input wire logic [7:0] RDATA,        // Read data.
  input wire logic       STOP_REQ,     // Stop entry.
  input wire logic       WAKE,         // Stop release.
  input wire logic       XTAL_TICK,    // Crystal pin.
  input wire logic       XTAL_RUNNING, // Crystal started.
  input wire logic       RING_TICK,    // Ring pin.
  input wire logic       CPU_READY,    // Wait over.
  input wire logic       XTAL_EN,      // Crystal enable.
  input wire logic       RING_EN,      // Ring enable.
  input wire logic [7:0] PRESC_OUT     // Prescaler taps.
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_unmapped_read_zero: assert property (RD && ADDR > 4'h3 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_status_top_first: assert property (RD && ADDR == 4'h1 |=>
    RDATA[7:5] == 3'h0 && (~RDATA[4:0] & (~RDATA[4:0] + 5'h01)) == 5'h00)
    else $error("status bits not set from the top");
  a_stop_drops_ready: assert property (STOP_REQ && CPU_READY |=> !CPU_READY && !XTAL_EN)
    else $error("stop entry did not halt the clock");
  a_stop_holds: assert property (!XTAL_EN && !WAKE |=> !XTAL_EN && !CPU_READY)
    else $error("stop left without release");
  a_ready_after_osc: assert property ($rose(CPU_READY) |-> $past(XTAL_RUNNING, 4))
    else $error("wait ended before oscillation start");
  a_ready_not_early: assert property ($fell(XTAL_EN) |-> !CPU_READY [*8])
    else $error("wait ended too soon");
  a_ring_stop_gated: assert property ($fell(RING_EN) |-> RING_STOP_ALLOWED == 1'b1)
    else $error("ring stopped without option");
  a_presc_frozen: assert property (($stable(XTAL_TICK) && $stable(RING_TICK)) [*4]
    |=> $stable(PRESC_OUT))
    else $error("prescaler moved without source edges");
endmodule
bind osc_ctrl osc_ctrl_props #(.RING_STOP_ALLOWED(RING_STOP_ALLOWED)) u_props (.SYS_CLK, .NRST,
  .ADDR, .RD, .RDATA, .STOP_REQ, .WAKE, .XTAL_TICK, .XTAL_RUNNING, .RING_TICK, .CPU_READY,
  .XTAL_EN, .RING_EN, .PRESC_OUT);

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import osc_ctrl_pkg::*;
  logic        SYS_CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, STOP_REQ = 1'b0;
  logic        WAKE = 1'b0, XTAL_TICK = 1'b0, XTAL_RUNNING = 1'b0, RING_TICK = 1'b0;
  logic        xt_on = 1'b0, rg_on = 1'b0, CPU_READY, XTAL_EN, RING_EN;
  logic [3:0]  ADDR = 4'h0;
  logic [7:0]  WDATA = 8'h00, RDATA, PRESC_OUT, rv, pv;
  logic [2:0]  CPU_DIV;
  logic [15:0] lfsr = 16'h0010;
  int          err_total = 0, n_checks = 0, n_edge = 0, e0;
  osc_ctrl uut (.SYS_CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .STOP_REQ, .WAKE, .XTAL_TICK,
    .XTAL_RUNNING, .RING_TICK, .CPU_READY, .XTAL_EN, .RING_EN, .PRESC_OUT, .CPU_DIV);
  always #20 SYS_CLK = ~SYS_CLK;
  // Pins toggle every cycle, so rising edges come every second cycle and the synchronizers never miss one.
  always @(posedge SYS_CLK) begin
    if (xt_on) XTAL_TICK <= ~XTAL_TICK;
    if (rg_on) RING_TICK <= ~RING_TICK;
    if (xt_on && !XTAL_TICK && XTAL_RUNNING) n_edge <= n_edge + 1;
  end
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] exp_st(input int n);
    return {3'h0, ~(5'h1f >> (n + 1))};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    @(negedge SYS_CLK);
    d = RDATA;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1600000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge SYS_CLK);
    NRST <= 1'b1;
    rd(ADDR_STAB_SEL, rv); chk(rv, 8'h05);
    rd(ADDR_STAB_STATUS, rv); chk(rv, 8'h00);
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      wr(lfsr[3:0] | 4'h4, lfsr[15:8]);
      rd(lfsr[3:0] | 4'h4, rv); chk(rv, 8'h00);
      wr(ADDR_STAB_SEL, lfsr[7:0]);
      rd(ADDR_STAB_SEL, rv); chk(rv, {5'h00, lfsr[2:0]});
    end
    for (int n = 0; n < 2; n++) begin
      wr(ADDR_STAB_SEL, 8'(n));
      @(posedge SYS_CLK);
      STOP_REQ <= 1'b1;
      @(posedge SYS_CLK);
      STOP_REQ <= 1'b0;
      rd(ADDR_STAB_STATUS, rv); chk(rv, 8'h00);
      chk(XTAL_EN, 1'b0);
      xt_on = 1'b1;
      @(posedge SYS_CLK);
      WAKE <= 1'b1;
      @(posedge SYS_CLK);
      WAKE <= 1'b0;
      repeat (300) @(negedge SYS_CLK);
      chk(CPU_READY, 1'b0);
      @(posedge SYS_CLK);
      XTAL_RUNNING <= 1'b1;
      e0 = n_edge;
      for (int k = 0; k < 20000 && CPU_READY !== 1'b1; k++) @(negedge SYS_CLK);
      chk(n_edge - e0 >= (2048 << n) + 4 && n_edge - e0 <= (2048 << n) + 10, 1'b1);
      rd(ADDR_STAB_STATUS, rv); chk(rv, exp_st(n));
      @(posedge SYS_CLK);
      xt_on <= 1'b0;
      XTAL_RUNNING <= 1'b0;
    end
    wr(ADDR_CLK_CTRL, 8'h10);
    rg_on = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    pv = PRESC_OUT;
    repeat (40) @(negedge SYS_CLK);
    chk(PRESC_OUT !== pv, 1'b1);
    rg_on = 1'b0;
    xt_on = 1'b1;
    repeat (6) @(negedge SYS_CLK);
    pv = PRESC_OUT;
    repeat (40) @(negedge SYS_CLK);
    chk(PRESC_OUT, pv);
    xt_on = 1'b0;
    wr(ADDR_CLK_CTRL, 8'h0d);
    rd(ADDR_CLK_CTRL, rv); chk(rv, 8'h0d);
    repeat (3) @(negedge SYS_CLK);
    chk(RING_EN, 1'b0);
    chk(CPU_DIV, 3'h5);
    final_report;
  end
endmodule

// File: verilog/osc_ctrl.sv
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// (RULE1) Software writes select after status confirms time
// (RULE2) Ring clock stop: select not shorter than checked
// (RULE3) Wait counter stops at selected time
// (RULE4) Status reports only up to selection
// (RULE5) Wait counts only after oscillation starts
// (RULE6) Ring clock feeds prescaler when selected
// (RULE7) Ring stop honoured only if option allows
// (RULE8) Software avoids forbidden divider codes on ring
// (RULE9) Status bits set from top, stay set
// (RULE10) Software sets select before stop entry
// (RULE11) Status cleared on stop entry
module osc_ctrl
  import osc_ctrl_pkg::*;
#(
  parameter bit RING_STOP_ALLOWED = 1'b1
)(
  input  wire logic       SYS_CLK,      // System clock, 25 MHz.
  input  wire logic       NRST,         // Synchronous reset, active low.
  input  wire logic [3:0] ADDR,         // Register address.
  input  wire logic [7:0] WDATA,        // Write data.
  input  wire logic       WR,           // Write strobe.
  input  wire logic       RD,           // Read strobe.
  output logic      [7:0] RDATA,        // Read data, cycle after RD.
  input  wire logic       STOP_REQ,     // Stop mode entry pulse.
  input  wire logic       WAKE,         // Stop release pulse (reset or interrupt).
  input  wire logic       XTAL_TICK,    // Crystal clock edge pin.
  input  wire logic       XTAL_RUNNING, // Crystal oscillation started pin.
  input  wire logic       RING_TICK,    // Ring oscillator edge pin.
  output logic            CPU_READY,    // Wait over, CPU clock may run.
  output logic            XTAL_EN,      // Crystal oscillator enable.
  output logic            RING_EN,      // Ring oscillator enable.
  output logic [PRESC_W-1:0] PRESC_OUT, // Prescaler divided clock taps.
  output logic [2:0]      CPU_DIV       // CPU clock divider code.
);

  logic [2:0] xt_s1, xt_s2, xt_s3;
  logic [1:0] rg_s1, rg_s2, rg_s3;
  logic [2:0] sync_nxt;
  logic [1:0] rsync_nxt;
  logic xtal_tick, xtal_run, ring_tick;

  // Crystal and ring pins are asynchronous, so each passes two flip-flops first.
  always_comb begin
    sync_nxt = {XTAL_TICK, XTAL_RUNNING, 1'b0};
    rsync_nxt = {RING_TICK, 1'b0};
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      xt_s1 <= '0;
      xt_s2 <= '0;
      xt_s3 <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
      rg_s3 <= '0;
    end else begin
      xt_s1 <= sync_nxt;
      xt_s2 <= xt_s1;
      xt_s3 <= xt_s2;
      rg_s1 <= rsync_nxt;
      rg_s2 <= rg_s1;
      rg_s3 <= rg_s2;
    end
  end

  // A rising edge is a high second stage over a low third stage.
  // Reading the first stage here would let a metastable value leak into the counters.
  function automatic logic rise_of(input logic cur, input logic prev);
    rise_of = cur & ~prev;
  endfunction

  assign xtal_tick = rise_of(xt_s2[2], xt_s3[2]);
  assign xtal_run  = xt_s2[1];
  assign ring_tick = rise_of(rg_s2[1], rg_s3[1]);

  // Registers.
  logic [STAB_SEL_W-1:0] sel_r, sel_nxt;
  clk_ctrl_s ctrl_r, ctrl_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [STAB_LEVELS-1:0] status;
  logic done;
  osc_state_e st_r, st_nxt;
  logic [2:0] gap_r, gap_nxt;
  logic [PRESC_W-1:0] presc_r, presc_nxt;
  logic clear, cnt_tick, src_tick;

  // Writes to unmapped offsets fall through the default branch and are lost.
  // Divider codes that are illegal on the ring clock are stored as written; keeping
  // clear of them is left to software, since the hardware cannot know the intent.
  // The state register reports the one-hot state beside the done flag.
  always_comb begin
    sel_nxt = sel_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = 8'h00;
    if (WR) begin
      case (ADDR)
        ADDR_STAB_SEL: sel_nxt = WDATA[STAB_SEL_W-1:0];
        ADDR_CLK_CTRL: ctrl_nxt = clk_ctrl_s'(WDATA[CTRL_DIV_LSB+CTRL_DIV_W-1:0]);
        default: ;
      endcase
    end
    if (RD) begin
      case (ADDR)
        ADDR_STAB_SEL:    rdata_nxt = 8'(sel_r);
        ADDR_STAB_STATUS: rdata_nxt = 8'(status);
        ADDR_CLK_CTRL:    rdata_nxt = 8'(ctrl_r);
        ADDR_CLK_STATUS:  rdata_nxt = 8'({st_r, done});
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      sel_r <= STAB_SEL_RESET;
      ctrl_r <= clk_ctrl_s'(CTRL_RESET[4:0]);
      rdata_r <= 8'h00;
    end else begin
      sel_r <= sel_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Stop / wake sequencing.
  // A stop request outside RUN is ignored, so a late pulse cannot clear fresh status.
  // The gap counter is three bits wide; the start gap must not exceed eight ticks.
  always_comb begin
    st_nxt = st_r;
    gap_nxt = gap_r;
    clear = 1'b0;
    case (st_r)
      ST_RUN: begin
        if (STOP_REQ) begin
          st_nxt = ST_STOP;
          clear = 1'b1; // (RULE11)
        end
      end
      ST_STOP: begin
        if (WAKE) begin
          st_nxt = ST_START;
          gap_nxt = '0;
        end
      end
      ST_START: begin
        // No counting until the crystal reports oscillation and settles a few ticks.
        if (xtal_run && xtal_tick) begin // (RULE5)
          gap_nxt = gap_r + 3'h1;
          if (gap_r == 3'(START_GAP_TICKS - 1))
            st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // The counter stops at the selected limit, so done stays high until the next stop or a write of a longer select.
        if (done)
          st_nxt = ST_RUN;
      end
      default: st_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      st_r <= ST_RUN;
      gap_r <= '0;
    end else begin
      st_r <= st_nxt;
      gap_r <= gap_nxt;
    end
  end

  assign cnt_tick = (st_r == ST_WAIT) && xtal_tick; // (RULE5)

  stab_counter u_stab (
    .SYS_CLK (SYS_CLK),
    .NRST    (NRST),
    .clear   (clear),
    .tick    (cnt_tick),
    .sel     (sel_r),
    .status  (status),
    .done    (done)
  );

  // Prescaler source follows the CPU clock selection.
  assign src_tick = ctrl_r.ring_sel ? ring_tick : xtal_tick; // (RULE6)

  // The taps are held during stop and the wait, so they never run on an unsettled clock.
  always_comb begin
    presc_nxt = presc_r;
    if (src_tick && st_r == ST_RUN)
      presc_nxt = presc_r + PRESC_W'(1);
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST)
      presc_r <= '0;
    else
      presc_r <= presc_nxt;
  end

  // Read data is cleared when no read is pending, so it stands for one cycle only.
  assign RDATA = rdata_r;
  assign CPU_READY = (st_r == ST_RUN);
  assign XTAL_EN = (st_r != ST_STOP);
  // The stop bit only bites when the build option allows it and the CPU is not on the ring.
  assign RING_EN = !(RING_STOP_ALLOWED && ctrl_r.ring_stop && !ctrl_r.ring_sel); // (RULE7)
  assign PRESC_OUT = presc_r;
  assign CPU_DIV = ctrl_r.div;

endmodule

// File: verilog/osc_ctrl_pkg.sv
package osc_ctrl_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_STAB_SEL    = 4'h0;
  localparam logic [3:0] ADDR_STAB_STATUS = 4'h1;
  localparam logic [3:0] ADDR_CLK_CTRL    = 4'h2;
  localparam logic [3:0] ADDR_CLK_STATUS  = 4'h3;

  // Stabilization select codes: 3 bits, code n up to 4 waits 2^(STAB_BASE_LOG2+n) ticks; codes above 4 wait as code 4.
  localparam int          STAB_SEL_W     = 3;
  localparam int          STAB_LEVELS    = 5;
  localparam logic [2:0]  STAB_SEL_RESET = 3'h5;
  localparam int          STAB_BASE_LOG2 = 11;
  localparam int          STAB_CNT_W     = 17;

  // Control register field constants; clk_ctrl_s puts div in 2:0, ring_stop at 3, ring_sel at 4.
  localparam int CTRL_RING_SEL_BIT = 0;
  localparam int CTRL_RING_STOP_BIT = 1;
  localparam int CTRL_DIV_LSB      = 2;
  localparam int CTRL_DIV_W        = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Prescaler divide chain width.
  localparam int PRESC_W = 8;

  // Oscillator start delay after wake, in crystal ticks, before counting.
  localparam int START_GAP_TICKS = 4;

  typedef struct packed {
    logic       ring_sel;
    logic       ring_stop;
    logic [2:0] div;
  } clk_ctrl_s;

  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_STOP  = 4'b0010,
    ST_START = 4'b0100,
    ST_WAIT  = 4'b1000
  } osc_state_e;

endpackage

// File: verilog/stab_counter.sv
`timescale 1ns/1ps
module stab_counter
  import osc_ctrl_pkg::*;
(
  input  wire logic                  SYS_CLK,   // System clock.
  input  wire logic                  NRST,      // Synchronous reset, active low.
  input  wire logic                  clear,     // Restart progression.
  input  wire logic                  tick,      // Crystal tick enable.
  input  wire logic [STAB_SEL_W-1:0] sel,       // Selected stabilization time.
  output logic [STAB_LEVELS-1:0]     status,    // Progress bits, top bit first.
  output logic                       done       // Selected time reached.
);

  logic [STAB_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [STAB_LEVELS-1:0] status_r, status_nxt;

  function automatic logic [STAB_CNT_W-1:0] limit_of(input logic [STAB_SEL_W-1:0] s);
    logic [STAB_SEL_W-1:0] c;
    c = (s > STAB_SEL_W'(STAB_LEVELS - 1)) ? STAB_SEL_W'(STAB_LEVELS - 1) : s;
    limit_of = STAB_CNT_W'(1) << (STAB_BASE_LOG2 + int'(c));
  endfunction

  always_comb begin
    cnt_nxt = cnt_r;
    status_nxt = status_r;
    if (clear) begin
      cnt_nxt = '0;
      status_nxt = '0;
    end else if (tick && (cnt_r < limit_of(sel))) begin
      cnt_nxt = cnt_r + STAB_CNT_W'(1); // (RULE3)
    end
    // Bits fill from the top as each level is passed, capped at the selection.
    for (int i = 0; i < STAB_LEVELS; i++) begin
      if (!clear && (cnt_r >= (STAB_CNT_W'(1) << (STAB_BASE_LOG2 + i))) && i <= int'(sel))
        status_nxt[STAB_LEVELS-1-i] = 1'b1; // (RULE4) (RULE9)
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      cnt_r <= '0;
      status_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      status_r <= status_nxt;
    end
  end

  assign status = status_r;
  assign done = (cnt_r >= limit_of(sel));

endmodule
